// File: usu_params.svh
`ifndef USU_PARAMS_SVH
`define USU_PARAMS_SVH

// wire mode codes
`define USU_WM_OFF 2'h0
`define USU_WM_THREE 2'h1
`define USU_WM_TWO 2'h2
`define USU_WM_TWO_HOLD 2'h3

// counter and data register values
`define USU_CNT_MAX 4'hF
`define USU_CNT_ONE 4'h1
`define USU_CNT_RST 4'h0
`define USU_DATA_RST 8'h00

// start detector sda delay, in ns and in link clock cycles (least time rounds up)
`define USU_SDA_DLY_MIN_NS 50
`define USU_SDA_DLY_MAX_NS 300
`define USU_LINK_CLK_NS 12
`define USU_SDA_DLY_CYC ((`USU_SDA_DLY_MIN_NS + `USU_LINK_CLK_NS - 1) / `USU_LINK_CLK_NS)

// system clock period, for reference of the serial rate ceiling
`define USU_SYS_CLK_NS 50
`define USU_SYNC_STAGES 2

`endif

// File: usu_pkg.sv
package usu_pkg;

    // control register image
    typedef struct packed {
        logic start_ie;
        logic ovf_ie;
        logic [1:0] wire_mode;
        logic clock_source_external_bit;
        logic clock_edge_select_bit;
        logic clock_strobe;
        logic toggle_clock_strobe;
    } usu_ctrl_s;

    // status register image
    typedef struct packed {
        logic start_condition_flag;
        logic counter_overflow_flag;
        logic stop_flag;
        logic collision;
        logic [3:0] count;
    } usu_status_s;

    // port direction bits of the pins used by the unit
    typedef struct packed {
        logic do_en;
        logic sda_en;
        logic clk_en;
    } usu_dir_s;

    // pin drive: value and active-low output enable per pin
    typedef struct packed {
        logic do_val;
        logic do_oe_b;
        logic sda_val;
        logic sda_oe_b;
        logic clk_val;
        logic clk_oe_b;
    } usu_pin_s;

endpackage

// File: usu_sync.sv
`timescale 1ns/1ps
`include "usu_params.svh"

module usu_sync #(
    parameter int W = 1
) (
    // clock, reset and enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic en,
    // level in and synchronised level out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta;

    // two stages; the first is read only by the second
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta <= '0;
            q <= '0;
        end else if (en) begin
            meta <= d;
            q <= meta;
        end
    end

endmodule

// File: usu_shift_unit.sv
`timescale 1ns/1ps
`include "usu_params.svh"


module usu_shift_unit (
    // system clock domain
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // link clock for the start detector
    input wire logic link_clk,
    // register writes from the processor
    input wire logic ctrl_wr,
    input wire usu_pkg::usu_ctrl_s ctrl_wdata,
    input wire logic status_wr,
    input wire usu_pkg::usu_status_s status_wdata,
    input wire logic data_wr,
    input wire logic [7:0] data_wdata,
    // timer 0 compare match pulse
    input wire logic tim0_match,
    // port direction bits
    input wire usu_pkg::usu_dir_s port_direction_register,
    // pin inputs
    input wire logic serial_clock_pin,
    input wire logic serial_in_pin,
    // pin drive
    output usu_pkg::usu_pin_s pin_drive,
    // register read images
    output logic [7:0] serial_shift_register,
    output usu_pkg::usu_status_s serial_status_register,
    output usu_pkg::usu_ctrl_s serial_control_register
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [1:0] wire_mode;
    logic start_ie;
    logic ovf_ie;
    logic ext_src;
    logic edge_sel;
    logic strobe_count;
    logic [7:0] shreg;
    logic out_latch;
    logic [3:0] count;
    logic ovf_flag;
    logic start_flag;
    logic start_hold;
    logic clk_level;
    logic sck_d;
    logic tgl_d;
    logic [2:0] sys_sync_q;
    logic start_tgl;
    logic [2:0] link_sync_q;
    logic [`USU_SDA_DLY_CYC:0] sda_dly;

    ////////////////////////////////////////////////////////////////////////////
    // pin and event synchronisers into the system domain

    // frozen with ce, like every other system-domain flop
    usu_sync #(.W(3)) sys_sync (
        .clk(clk),
        .rst_b(rst_b),
        .en(ce),
        .d({start_tgl, serial_in_pin, serial_clock_pin}),
        .q(sys_sync_q)
    );

    wire sck_s = sys_sync_q[0];
    wire din_s = sys_sync_q[1];
    wire tgl_s = sys_sync_q[2];

    // edges seen only at or below a quarter of clk are reliable
    wire sck_rise = sck_s & ~sck_d;
    wire sck_fall = ~sck_s & sck_d;
    wire start_ev = tgl_s ^ tgl_d;

    ////////////////////////////////////////////////////////////////////////////
    // mode decode

    wire two_wire = wire_mode[1];
    wire three_wire = (wire_mode == `USU_WM_THREE);
    wire ovf_hold_mode = (wire_mode == `USU_WM_TWO_HOLD);

    // mode 0 samples on rising, shifts output on falling; mode 1 reversed
    wire sample_edge = edge_sel ? sck_fall : sck_rise;
    wire change_edge = edge_sel ? sck_rise : sck_fall;

    // write-side strobes use the value being written
    wire wr_strobe = ctrl_wr & ctrl_wdata.clock_strobe;
    wire sw_strobe = wr_strobe & ~ctrl_wdata.clock_source_external_bit
        & ~ctrl_wdata.clock_edge_select_bit;
    wire toggle_ev = ctrl_wr & ctrl_wdata.toggle_clock_strobe;
    wire toggle_count = toggle_ev & wr_strobe & ctrl_wdata.clock_source_external_bit;
    wire tim_ev = ~ext_src & edge_sel & tim0_match;

    // shift on sampling edge, timer match or software strobe
    wire shift_ev = (ext_src & sample_edge) | tim_ev | sw_strobe;

    // external pin clock counts both edges unless counting toggle strobes
    wire pin_count = ext_src & ~strobe_count & (sck_rise | sck_fall);
    wire count_ev = pin_count | toggle_count | tim_ev | sw_strobe;
    wire ovf_ev = count_ev & (count == `USU_CNT_MAX);

    ////////////////////////////////////////////////////////////////////////////
    // next values

    // a processor write wins over a shift in the same cycle
    wire [7:0] next_shreg = data_wr ? data_wdata : (shift_ev ? {shreg[6:0], din_s} : shreg);

    // status write loads the counter while it clears flags
    wire [3:0] next_count = status_wr ? status_wdata.count
        : (count_ev ? count + `USU_CNT_ONE : count);

    // set beats clear when both land in one cycle
    wire ovf_clr = status_wr & status_wdata.counter_overflow_flag;
    wire next_ovf_flag = ovf_ev | (ovf_flag & ~ovf_clr);

    // two-wire: start condition sets it; otherwise any count sets it
    wire start_set = two_wire ? start_ev : count_ev;
    wire start_clr = status_wr & status_wdata.start_condition_flag;
    wire next_start_flag = start_set | (start_flag & ~start_clr);

    // hold engages at the first falling clock edge after a start
    wire next_start_hold = two_wire & start_flag & (start_hold | sck_fall);

    // output latch follows msb at the change edge, or on a direct write
    wire latch_load = data_wr | change_edge;
    wire next_out_latch = latch_load ? next_shreg[7] : out_latch;

    ////////////////////////////////////////////////////////////////////////////
    // control register

    // clock strobe bit with external source selects toggle-strobe counting
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            start_ie <= 1'b0;
            ovf_ie <= 1'b0;
            wire_mode <= `USU_WM_OFF;
            ext_src <= 1'b0;
            edge_sel <= 1'b0;
            strobe_count <= 1'b0;
        end else if (ce && ctrl_wr) begin
            start_ie <= ctrl_wdata.start_ie;
            ovf_ie <= ctrl_wdata.ovf_ie;
            wire_mode <= ctrl_wdata.wire_mode;
            ext_src <= ctrl_wdata.clock_source_external_bit;
            edge_sel <= ctrl_wdata.clock_edge_select_bit;
            strobe_count <= ctrl_wdata.clock_strobe & ctrl_wdata.clock_source_external_bit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // shift register, counter and flags

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            shreg <= `USU_DATA_RST;
            out_latch <= 1'b0;
            count <= `USU_CNT_RST;
            ovf_flag <= 1'b0;
            start_flag <= 1'b0;
            start_hold <= 1'b0;
        end else if (ce) begin
            shreg <= next_shreg;
            out_latch <= next_out_latch;
            count <= next_count;
            ovf_flag <= next_ovf_flag;
            start_flag <= next_start_flag;
            start_hold <= next_start_hold;
        end
    end

    // software clock toggle and edge-detect history
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            clk_level <= 1'b0;
            sck_d <= 1'b0;
            tgl_d <= 1'b0;
        end else if (ce) begin
            clk_level <= clk_level ^ toggle_ev;
            sck_d <= sck_s;
            tgl_d <= tgl_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin drive

    // internal clock keeps the latch transparent on the register msb
    wire out_bit = ext_src ? out_latch : shreg[7];

    // clock held low by start detection or by overflow in hold mode
    wire scl_hold = two_wire & (start_hold | (ovf_hold_mode & ovf_flag));

    // two-wire lines are open drain: enable only when pulling low
    // a one in the msb leaves the line released, which is also how a byte goes unacknowledged
    wire sda_pull = two_wire & port_direction_register.sda_en & ~out_bit;
    wire scl_pull = scl_hold | (two_wire & port_direction_register.clk_en & ~clk_level);

    // wire mode 00 leaves every pin to the port
    always_comb begin
        pin_drive.do_val = out_bit;
        pin_drive.do_oe_b = ~(three_wire & port_direction_register.do_en);
        pin_drive.sda_val = 1'b0;
        pin_drive.sda_oe_b = ~sda_pull;
        pin_drive.clk_val = three_wire & clk_level;
        pin_drive.clk_oe_b = ~(scl_pull | (three_wire & port_direction_register.clk_en));
    end

    ////////////////////////////////////////////////////////////////////////////
    // read images

    // strobe bits read as zero; stop and collision are not implemented
    assign serial_shift_register = shreg;
    assign serial_status_register = '{
        start_condition_flag: start_flag,
        counter_overflow_flag: ovf_flag,
        stop_flag: 1'b0,
        collision: 1'b0,
        count: count
    };
    assign serial_control_register = '{
        start_ie: start_ie,
        ovf_ie: ovf_ie,
        wire_mode: wire_mode,
        clock_source_external_bit: ext_src,
        clock_edge_select_bit: edge_sel,
        clock_strobe: 1'b0,
        toggle_clock_strobe: 1'b0
    };

    ////////////////////////////////////////////////////////////////////////////
    // start detector on the link clock

    // runs without ce so it still sees a start while the system is frozen
    usu_sync #(.W(3)) link_sync (
        .clk(link_clk),
        .rst_b(rst_b),
        .en(1'b1),
        .d({two_wire, serial_clock_pin, serial_in_pin}),
        .q(link_sync_q)
    );

    wire sda_l = link_sync_q[0];
    wire scl_l = link_sync_q[1];
    wire tw_l = link_sync_q[2];

    assign sda_dly[0] = sda_l;

    // sda delay line so scl is sampled after it has settled
    genvar gi;
    generate
        for (gi = 0; gi < `USU_SDA_DLY_CYC; gi++) begin : g_dly
            always_ff @(posedge link_clk or negedge rst_b) begin
                if (!rst_b) begin
                    sda_dly[gi + 1] <= 1'b1;
                end else begin
                    sda_dly[gi + 1] <= sda_dly[gi];
                end
            end
        end
    endgenerate

    // delayed data falls while clock high: a start condition
    wire start_det = tw_l & scl_l & ~sda_dly[`USU_SDA_DLY_CYC - 1]
        & sda_dly[`USU_SDA_DLY_CYC];

    // toggle carries the event across to the system domain
    always_ff @(posedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            start_tgl <= 1'b0;
        end else begin
            start_tgl <= start_tgl ^ start_det;
        end
    end

endmodule

// File: usu_monitor.sv
`timescale 1ns/1ps
module usu_monitor (
    // clock, reset and enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // register writes and timer match
    input wire logic ctrl_wr,
    input wire usu_pkg::usu_ctrl_s ctrl_wdata,
    input wire logic status_wr,
    input wire usu_pkg::usu_status_s status_wdata,
    input wire logic tim0_match,
    // unit outputs
    input wire usu_pkg::usu_pin_s pin_drive,
    input wire usu_pkg::usu_status_s serial_status_register,
    input wire usu_pkg::usu_ctrl_s serial_control_register
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////
    // short names; a status write wins over any count event
    usu_pkg::usu_status_s st;
    logic sw;
    assign st = serial_status_register;
    assign sw = ce && status_wr;
    ////////////////////////////////////////////////////////////////
    count_load_a: assert property (sw |=> st.count == $past(status_wdata.count))
        else $error("counter load lost");
    ovf_clear_a: assert property (
        sw && status_wdata.counter_overflow_flag && st.count != 4'hF
        |=> !st.counter_overflow_flag) else $error("overflow flag not cleared");
    ovf_set_a: assert property (
        (ce && !sw && st.count == 4'hF) ##1 st.count == 4'h0 |-> st.counter_overflow_flag)
        else $error("wrap without overflow flag");
    ovf_keep_a: assert property (
        st.counter_overflow_flag && !(sw && status_wdata.counter_overflow_flag)
        |=> st.counter_overflow_flag) else $error("overflow flag dropped");
    start_keep_a: assert property (
        st.start_condition_flag && !(sw && status_wdata.start_condition_flag)
        |=> st.start_condition_flag) else $error("start flag dropped");
    toggle_count_a: assert property (
        ce && ctrl_wr && !sw && ctrl_wdata == 8'h1B
        |=> st.count == $past(st.count) + 4'h1 && $changed(pin_drive.clk_val))
        else $error("toggle strobe missed");
    strobe_count_a: assert property (
        ce && ctrl_wr && !sw && ctrl_wdata[3:1] == 3'h1 |=> st.count == $past(st.count) + 4'h1)
        else $error("clock strobe missed");
    timer_count_a: assert property (
        ce && tim0_match && !sw && !ctrl_wr && serial_control_register[3:2] == 2'h1
        |=> st.count == $past(st.count) + 4'h1) else $error("timer match missed");
    off_mode_a: assert property (
        serial_control_register[5:4] == 2'h0 |-> (pin_drive & 6'h15) == 6'h15)
        else $error("pin driven with outputs off");
    open_drain_a: assert property (
        serial_control_register[5] |-> !pin_drive.sda_val && !pin_drive.clk_val)
        else $error("two-wire line driven high");
endmodule

bind usu_shift_unit usu_monitor mon (.clk(clk), .rst_b(rst_b), .ce(ce), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .status_wr(status_wr), .status_wdata(status_wdata),
    .tim0_match(tim0_match), .pin_drive(pin_drive),
    .serial_status_register(serial_status_register),
    .serial_control_register(serial_control_register));

// File: usu_far_end.sv
`timescale 1ns/1ps
module usu_far_end (
    // unit pin drive and remote master lines
    input wire usu_pkg::usu_pin_s pins,
    input wire logic m_scl,
    input wire logic m_sda,
    input wire logic two_wire,
    // reply byte load
    input wire logic ld,
    input wire logic [7:0] tx,
    // resolved lines and byte taken in
    output logic scl,
    output logic sda,
    output logic [7:0] rx
);
    logic [7:0] sh = 8'h00;
    ////////////////////////////////////////////////////////////////
    // clock line, and data line in two-wire, pulled up; a released line reads high, never the last value
    assign scl = (pins.clk_oe_b | pins.clk_val) & m_scl;
    assign sda = two_wire ? (pins.sda_oe_b | pins.sda_val) & m_sda : sh[7];
    // remote shifter: samples on rise, changes on fall, like mode 0
    // no keeper on the data-out wire: a released output reads inverted so it cannot pass
    always @(posedge scl) rx <= {rx[6:0], pins.do_oe_b ? ~pins.do_val : pins.do_val};
    always @(negedge scl or posedge ld) sh <= ld ? tx : {sh[6:0], sh[7]};
endmodule

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic link_clk = 1'b1;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic ctrl_wr = 1'b0;
    logic status_wr = 1'b0;
    logic data_wr = 1'b0;
    logic tim0_match = 1'b0;
    usu_pkg::usu_ctrl_s ctrl_wdata = 8'h00;
    usu_pkg::usu_status_s status_wdata = 8'h00;
    logic [7:0] data_wdata = 8'h00;
    usu_pkg::usu_dir_s dir = 3'h0;
    logic m_scl = 1'b0;
    logic m_sda = 1'b1;
    logic two_wire = 1'b0;
    logic ld = 1'b0;
    logic [7:0] tx = 8'h00;
    logic [7:0] b = 8'h00;
    logic scl;
    logic sda;
    logic [7:0] rx;
    logic [7:0] shreg;
    usu_pkg::usu_pin_s pins;
    usu_pkg::usu_status_s st;
    usu_pkg::usu_ctrl_s cr;
    int fail_count = 0;
    int n_tests = 0;
    ////////////////////////////////////////////////////////////////
    // unrelated system and link clocks
    always #25 clk = ~clk;
    always #6 link_clk = ~link_clk;
    usu_shift_unit DUT (.clk(clk), .rst_b(rst_b), .ce(ce), .link_clk(link_clk),
        .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .status_wr(status_wr),
        .status_wdata(status_wdata), .data_wr(data_wr), .data_wdata(data_wdata),
        .tim0_match(tim0_match), .port_direction_register(dir), .serial_clock_pin(scl),
        .serial_in_pin(sda), .pin_drive(pins), .serial_shift_register(shreg),
        .serial_status_register(st), .serial_control_register(cr));
    usu_far_end far (.pins(pins), .m_scl(m_scl), .m_sda(m_sda), .two_wire(two_wire),
        .ld(ld), .tx(tx), .scl(scl), .sda(sda), .rx(rx));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    // k: 0 control, 1 status, 2 data; one-cycle strobe
    task automatic wr(input int k, input logic [7:0] v);
        @(negedge clk);
        {ctrl_wr, status_wr, data_wr} = 3'b100 >> k;
        ctrl_wdata = v;
        status_wdata = v;
        data_wdata = v;
        @(negedge clk);
        {ctrl_wr, status_wr, data_wr} = 3'b000;
    endtask
    task automatic wait_st(input int i);
        for (int n = 0; n < 300; n++) begin
            if (st[i] === 1'b1)
                return;
            @(negedge clk);
        end
        chk("flag wait", 8'h01, 8'h00);
        give_verdict();
    endtask
    // one byte each way over three wires; unit as master or as slave
    task automatic xfer3(input bit mst);
        b = 8'($urandom);
        tx = 8'($urandom);
        wr(2, b);
        ld = 1'b1;
        wr(1, 8'hC0);
        ld = 1'b0;
        for (int e = 0; e < 16; e++) begin
            if (mst)
                wr(0, 8'h1B);
            else
                m_scl = ~m_scl;
            idle(4);
        end
        idle(4);
        chk("byte ovf", 8'h40, st & 8'h4F);
        chk("unit rx", tx, shreg);
        chk("far rx", b, rx);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hf22c));
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst_b = 1'b1;
        chk("status rst", 8'h00, st);
        chk("ctrl rst", 8'h00, cr);
        chk("pins rst", 8'h15, {2'b00, pins});
        $display("reset test done");
        // three-wire slave on the remote clock, then a single-edge overflow
        dir = 3'b100;
        wr(0, 8'h18);
        xfer3(1'b0);
        wr(1, 8'hCF);
        m_scl = 1'b1;
        idle(8);
        chk("edge irq", 8'h40, st & 8'h4F);
        m_scl = 1'b0;
        idle(4);
        $display("three-wire slave test done");
        // master by toggle strobes; last toggle leaves the clock high
        dir = 3'b101;
        wr(0, 8'h1A);
        chk("ctrl image", 8'h18, cr);
        idle(4);
        m_scl = 1'b1;
        xfer3(1'b1);
        wr(0, 8'h1B);
        idle(6);
        $display("three-wire master test done");
        // software strobe and timer match clocking
        wr(0, 8'h00);
        wr(2, 8'h5A);
        wr(1, 8'hCF);
        wr(0, 8'h02);
        idle(2);
        chk("strobe shift", 8'hB4, shreg & 8'hFE);
        chk("strobe ovf", 8'h40, st & 8'h4F);
        // a strobe written while frozen must neither shift nor count
        ce = 1'b0;
        wr(0, 8'h02);
        ce = 1'b1;
        chk("ce count", 8'h40, st & 8'h4F);
        chk("ce shreg", 8'hB4, shreg & 8'hFE);
        wr(0, 8'h04);
        wr(1, 8'hC0);
        repeat (16) begin
            tim0_match = 1'b1;
            idle(1);
            tim0_match = 1'b0;
            idle(1 + $urandom_range(2));
        end
        chk("timer ovf", 8'h40, st & 8'h4F);
        $display("strobe and timer test done");
        // start condition ignored with outputs off
        two_wire = 1'b1;
        dir = 3'b011;
        wr(2, 8'hFF);
        wr(0, 8'h08);
        wr(1, 8'hC0);
        m_sda = 1'b0;
        idle(20);
        chk("start off", 8'h00, st & 8'h80);
        chk("pins off", 8'h15, {2'b00, pins} & 8'h15);
        m_sda = 1'b1;
        idle(4);
        // two-wire slave: start, hold, address byte, acknowledge
        wr(0, 8'h38);
        wr(1, 8'hC0);
        idle(4);
        m_sda = 1'b0;
        wait_st(7);
        chk("start flag", 8'h80, st & 8'h80);
        m_scl = 1'b0;
        idle(8);
        chk("start hold", 8'h00, pins.clk_oe_b);
        m_scl = 1'b1;
        idle(4);
        chk("scl held", 8'h00, scl);
        m_scl = 1'b0;
        wr(1, 8'hC0);
        idle(4);
        chk("hold freed", 8'h01, pins.clk_oe_b);
        b = 8'($urandom);
        for (int i = 7; i >= 0; i--) begin
            m_sda = b[i];
            idle(3);
            m_scl = 1'b1;
            idle(4);
            m_scl = 1'b0;
            idle(4);
        end
        idle(2);
        chk("addr byte", b, shreg);
        chk("addr ovf", 8'h40, st & 8'h4F);
        chk("ovf hold", 8'h00, pins.clk_oe_b);
        // master lets go of data; slave software pulls it low for the acknowledge
        m_sda = 1'b1;
        wr(2, 8'h00);
        wr(1, 8'h4E);
        idle(4);
        chk("ack free", 8'h01, pins.clk_oe_b);
        chk("ack low", 8'h00, sda);
        m_scl = 1'b1;
        idle(4);
        m_scl = 1'b0;
        idle(6);
        chk("ack ovf", 8'h40, st & 8'h4F);
        chk("ack hold", 8'h00, pins.clk_oe_b);
        wr(0, 8'h00);
        $display("two-wire test done");
        give_verdict();
    end
endmodule
